//--- include/kbd_emul_cfg.svh
// Operation
// - With emulation on, port 60h/64h write data lands in the input byte register.
// - Input byte register is readable and writable at operational offset 104h.
// - Memory access to the input byte register only stores or returns data.
// - Input byte sits in bits 7..0; upper bits reserved; all reset to zero.
// - With emulation on, port 60h reads return the output byte register.
// - A port 60h read clears output-full, status bit 0; a software write that sets it in the same cycle wins.
// - Output byte sits in bits 7..0; upper bits reserved, reset zero.
// - With emulation on, port 64h reads return the status register.
// - Port 60h reads and port 60h/64h writes may update status flags.
// - Memory access to the status register has no side effects.
// - Outside a gate A20 sequence, port 60h/64h writes set input-full, except a port 64h write of D1h.
// - Port 60h write clears command/data flag; port 64h write sets it.
// - Port 64h write of D1h sets gate A20 sequence flag; other values clear it.
// - Port 60h/64h decoding works only while the emulation enable bit is set.
`ifndef KBD_EMUL_CFG_SVH
`define KBD_EMUL_CFG_SVH

// ----------------------------------------------------------------------------
// Offsets in operational space and legacy port numbers
// ----------------------------------------------------------------------------
`define KE_OFS_CONTROL   12'h100
`define KE_OFS_INPUT     12'h104
`define KE_OFS_OUTPUT    12'h108
`define KE_OFS_STATUS    12'h10C
`define KE_PORT_DATA     16'h0060
`define KE_PORT_CMD      16'h0064
`define KE_GA20_CMD      8'hD1

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define KE_CTL_EE        0
`define KE_CTL_GATE_A20_SEQUENCE_FLAG     5
`define KE_CTL_WIDTH     9
`define KE_ST_OUT_FULL   0
`define KE_ST_IN_FULL    1
`define KE_ST_CMD_DATA   3
`define KE_BYTE_RESET    8'h00
`define KE_CTL_RESET     9'h000

`endif

//--- include/kbd_emul_pkg.sv
package kbd_emul_pkg;

  typedef logic [7:0] byte_type;

  // Decoded legacy port event of one cycle.
  typedef enum logic [2:0] {
    EV_NONE,
    EV_WR_DATA,
    EV_WR_CMD,
    EV_RD_DATA,
    EV_RD_CMD
  } port_event_type;

endpackage

//--- include/kbd_emul_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries decoded port events from the decoder to the register core.
interface kbd_emul_if;
  kbd_emul_pkg::port_event_type event_kind;
  kbd_emul_pkg::byte_type       wr_byte;

  modport decoder (output event_kind, output wr_byte);
  modport core    (input event_kind, input wr_byte);
endinterface

`default_nettype wire

//--- hdl/legacy_port_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "kbd_emul_cfg.svh"

module legacy_port_decode (
  input  wire logic        io_sel,
  input  wire logic        io_wr,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        enable,
  kbd_emul_if.decoder      ev
);

  // ---------------------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------------------
  // Decoding is gated by the enable bit so a disabled block sees no events.
  always_comb begin
    ev.wr_byte    = io_wdata;
    ev.event_kind = kbd_emul_pkg::EV_NONE;
    if (io_sel && enable) begin
      if (io_addr == `KE_PORT_DATA) begin
        ev.event_kind = io_wr ? kbd_emul_pkg::EV_WR_DATA : kbd_emul_pkg::EV_RD_DATA;
      end else if (io_addr == `KE_PORT_CMD) begin
        ev.event_kind = io_wr ? kbd_emul_pkg::EV_WR_CMD : kbd_emul_pkg::EV_RD_CMD;
      end
    end
  end

endmodule // legacy_port_decode

`default_nettype wire

//--- hdl/legacy_keyboard_emulation_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "kbd_emul_cfg.svh"

module legacy_keyboard_emulation_regs (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        mem_sel,
  input  wire logic        mem_wr,
  input  wire logic [11:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack,
  input  wire logic        io_sel,
  input  wire logic        io_wr,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_ack,
  output logic             emulation_enable_bit,
  output logic             gate_a20_sequence_flag
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0]                 input_byte_q;
  logic [7:0]                 output_byte_q;
  logic [7:0]                 status_q;
  logic [`KE_CTL_WIDTH-1:0]   control_q;
  logic [31:0]                mem_rdata_q;
  logic                       mem_ack_q;
  logic [7:0]                 io_rdata_q;
  logic                       io_ack_q;
  logic [7:0]                 status_d;
  logic                       wr_input;
  logic                       wr_output;
  logic                       wr_status;
  logic                       wr_control;
  logic                       port_wr;
  logic                       in_full_hold;

  kbd_emul_if ev ();

  legacy_port_decode u_decode (
    .io_sel   (io_sel),
    .io_wr    (io_wr),
    .io_addr  (io_addr),
    .io_wdata (io_wdata),
    .enable   (control_q[`KE_CTL_EE]),
    .ev       (ev.decoder)
  );

  // Memory write strobe for one offset; used for all four registers.
  function automatic logic mem_hit(input logic [11:0] ofs);
    mem_hit = mem_sel && mem_wr && (mem_addr == ofs);
  endfunction

  assign wr_input   = mem_hit(`KE_OFS_INPUT);
  assign wr_output  = mem_hit(`KE_OFS_OUTPUT);
  assign wr_status  = mem_hit(`KE_OFS_STATUS);
  assign wr_control = mem_hit(`KE_OFS_CONTROL);
  assign port_wr    = (ev.event_kind == kbd_emul_pkg::EV_WR_DATA) ||
                      (ev.event_kind == kbd_emul_pkg::EV_WR_CMD);
  // The D1h command and any write while the sequence runs leave input-full alone.
  assign in_full_hold = control_q[`KE_CTL_GATE_A20_SEQUENCE_FLAG] ||
                        ((ev.event_kind == kbd_emul_pkg::EV_WR_CMD) &&
                         (ev.wr_byte == `KE_GA20_CMD));

  // ---------------------------------------------------------------------------
  // Input byte register
  // ---------------------------------------------------------------------------
  // A port write wins over a same-cycle memory write, since the byte is live data.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      input_byte_q <= `KE_BYTE_RESET;
    end else if (port_wr) begin
      input_byte_q <= ev.wr_byte;
    end else if (wr_input) begin
      input_byte_q <= mem_wdata[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Output byte register
  // ---------------------------------------------------------------------------
  // Only the low byte is kept; reserved bits are not stored and read as zero.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      output_byte_q <= `KE_BYTE_RESET;
    end else if (wr_output) begin
      output_byte_q <= mem_wdata[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------------------
  // Software value first, then port events; a software set of output-full
  // beats a same-cycle port read, and a port set of input-full beats a clear.
  always_comb begin
    status_d = wr_status ? mem_wdata[7:0] : status_q;
    case (ev.event_kind)
      kbd_emul_pkg::EV_WR_DATA: begin
        status_d[`KE_ST_CMD_DATA] = 1'b0;
        if (!in_full_hold) begin
          status_d[`KE_ST_IN_FULL] = 1'b1;
        end
      end
      kbd_emul_pkg::EV_WR_CMD: begin
        status_d[`KE_ST_CMD_DATA] = 1'b1;
        if (!in_full_hold) begin
          status_d[`KE_ST_IN_FULL] = 1'b1;
        end
      end
      kbd_emul_pkg::EV_RD_DATA: begin
        if (!(wr_status && mem_wdata[`KE_ST_OUT_FULL])) begin
          status_d[`KE_ST_OUT_FULL] = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= `KE_BYTE_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  // The sequence flag follows every command write; hardware wins over software.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      control_q <= `KE_CTL_RESET;
    end else begin
      if (wr_control) begin
        control_q <= mem_wdata[`KE_CTL_WIDTH-1:0];
      end
      if (ev.event_kind == kbd_emul_pkg::EV_WR_CMD) begin
        control_q[`KE_CTL_GATE_A20_SEQUENCE_FLAG] <= (ev.wr_byte == `KE_GA20_CMD);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Memory read path
  // ---------------------------------------------------------------------------
  // Reads answer one cycle later and never touch any flag.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_rdata_q <= 32'h00000000;
      mem_ack_q   <= 1'b0;
    end else begin
      mem_ack_q <= mem_sel;
      case (mem_addr)
        `KE_OFS_CONTROL: mem_rdata_q <= {23'h000000, control_q};
        `KE_OFS_INPUT:   mem_rdata_q <= {24'h000000, input_byte_q};
        `KE_OFS_OUTPUT:  mem_rdata_q <= {24'h000000, output_byte_q};
        `KE_OFS_STATUS:  mem_rdata_q <= {24'h000000, status_q};
        default:         mem_rdata_q <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Legacy port read path
  // ---------------------------------------------------------------------------
  // Only decoded port reads and writes are acknowledged; a disabled block leaves the cycle alone.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata_q <= 8'h00;
      io_ack_q   <= 1'b0;
    end else begin
      io_ack_q <= (ev.event_kind != kbd_emul_pkg::EV_NONE);
      case (ev.event_kind)
        kbd_emul_pkg::EV_RD_DATA: io_rdata_q <= output_byte_q;
        kbd_emul_pkg::EV_RD_CMD:  io_rdata_q <= status_q;
        default:                  io_rdata_q <= 8'h00;
      endcase
    end
  end

  assign mem_rdata              = mem_rdata_q;
  assign mem_ack                = mem_ack_q;
  assign io_rdata               = io_rdata_q;
  assign io_ack                 = io_ack_q;
  assign emulation_enable_bit   = control_q[`KE_CTL_EE];
  assign gate_a20_sequence_flag = control_q[`KE_CTL_GATE_A20_SEQUENCE_FLAG];

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence ga20_start_s;
    io_sel && io_wr && (io_addr == `KE_PORT_CMD) && (io_wdata == `KE_GA20_CMD)
      && control_q[`KE_CTL_EE] && !wr_control;
  endsequence

  // A data write while the sequence runs; software writes are excluded so the
  // flags can only move by hardware in that cycle.
  sequence data_write_s;
    io_sel && io_wr && (io_addr == `KE_PORT_DATA) && control_q[`KE_CTL_EE]
      && control_q[`KE_CTL_GATE_A20_SEQUENCE_FLAG] && !wr_status && !wr_control;
  endsequence

  capture_input_a : assert property (
    port_wr |=> input_byte_q == $past(io_wdata))
    else $error("Port write byte not captured.");

  mem_input_write_a : assert property (
    (wr_input && !port_wr) |=> input_byte_q == $past(mem_wdata[7:0]))
    else $error("Memory write of input byte lost.");

  mem_side_free_a : assert property (
    (mem_sel && !wr_status && ev.event_kind == kbd_emul_pkg::EV_NONE) |=> $stable(status_q))
    else $error("Memory access changed status.");

  port_data_read_a : assert property (
    (ev.event_kind == kbd_emul_pkg::EV_RD_DATA) |=> io_ack && io_rdata == $past(output_byte_q))
    else $error("Port 60h read returned wrong byte.");

  out_full_clear_a : assert property (
    (ev.event_kind == kbd_emul_pkg::EV_RD_DATA && !wr_status) |=> !status_q[`KE_ST_OUT_FULL])
    else $error("Output-full not cleared by port read.");

  status_read_a : assert property (
    (ev.event_kind == kbd_emul_pkg::EV_RD_CMD) |=> io_ack && io_rdata == $past(status_q))
    else $error("Port 64h read returned wrong status.");

  in_full_set_a : assert property (
    (port_wr && !in_full_hold) |=> status_q[`KE_ST_IN_FULL])
    else $error("Input-full not set by port write.");

  cmd_data_flag_a : assert property (
    port_wr |=> status_q[`KE_ST_CMD_DATA] == ($past(ev.event_kind) == kbd_emul_pkg::EV_WR_CMD))
    else $error("Command/data flag wrong after port write.");

  gate_sequence_a : assert property (
    ga20_start_s |=> gate_a20_sequence_flag)
    else $error("Gate A20 sequence not entered.");

  ga20_hold_a : assert property (
    data_write_s |=> gate_a20_sequence_flag && $stable(status_q[`KE_ST_IN_FULL]))
    else $error("Input-full changed during gate A20 sequence.");

  ga20_clear_a : assert property (
    (ev.event_kind == kbd_emul_pkg::EV_WR_CMD && ev.wr_byte != `KE_GA20_CMD)
      |=> !gate_a20_sequence_flag)
    else $error("Gate A20 sequence flag not cleared.");

  disabled_quiet_a : assert property (
    (io_sel && !control_q[`KE_CTL_EE] && !mem_sel) |=> !io_ack && $stable(input_byte_q)
      && $stable(status_q))
    else $error("Disabled block reacted to port cycle.");

endmodule // legacy_keyboard_emulation_regs

`default_nettype wire

//--- verification/legacy_port_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host processor side of the legacy ports: one-cycle I/O requests.
module legacy_port_host (
  input  wire logic        mclk,
  output logic             io_sel,
  output logic             io_wr,
  output logic      [15:0] io_addr,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_ack
);
  // Idle lines show inverted leftovers, so a stale value never looks valid.
  initial begin
    io_sel   = 1'b0;
    io_wr    = 1'b0;
    io_addr  = 16'hFFFF;
    io_wdata = 8'hFF;
  end

  // Drives on the falling edge and takes the answer half a cycle after the taking edge.
  task automatic port(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic ack, output logic [7:0] rd);
    @(negedge mclk);
    io_sel   = 1'b1;
    io_wr    = wr;
    io_addr  = a;
    io_wdata = d;
    @(negedge mclk);
    io_sel   = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
    ack      = io_ack;
    rd       = io_rdata;
  endtask
endmodule // legacy_port_host

`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "kbd_emul_cfg.svh"

module tb;
  logic        mclk;
  logic        rst_b;
  logic        mem_sel;
  logic        mem_wr;
  logic [11:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic        mem_ack;
  logic        io_sel;
  logic        io_wr;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        io_ack;
  logic        emulation_enable_bit;
  logic        gate_a20_sequence_flag;
  int          err_count;
  int          n_tests;
  int          in_b, out_b, st, ctl;

  legacy_keyboard_emulation_regs u_legacy_keyboard_emulation_regs (
    .mclk(mclk), .rst_b(rst_b), .mem_sel(mem_sel), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .io_sel(io_sel), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
    .emulation_enable_bit(emulation_enable_bit),
    .gate_a20_sequence_flag(gate_a20_sequence_flag));

  legacy_port_host u_legacy_port_host (
    .mclk(mclk), .io_sel(io_sel), .io_wr(io_wr), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack));

  // 25 MHz clock.
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // ---------------------------------------------------------------
  // Compare and closing tasks
  // ---------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("Checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One memory access; the model predicts reads and follows writes.
  task automatic mem(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] e;
    e = (a == `KE_OFS_CONTROL) ? ctl : (a == `KE_OFS_INPUT) ? in_b :
        (a == `KE_OFS_OUTPUT) ? out_b : (a == `KE_OFS_STATUS) ? st : 32'h0;
    @(negedge mclk);
    mem_sel   = 1'b1;
    mem_wr    = wr;
    mem_addr  = a;
    mem_wdata = d;
    @(negedge mclk);
    mem_sel   = 1'b0;
    mem_addr  = ~a;
    mem_wdata = ~d;
    chk_flag("mem_ack", 1'b1, mem_ack);
    if (!wr) chk_word("mem_rdata", e, mem_rdata);
    else if (a == `KE_OFS_CONTROL) ctl = {23'h0, d[8:0]};
    else if (a == `KE_OFS_INPUT) in_b = {24'h0, d[7:0]};
    else if (a == `KE_OFS_OUTPUT) out_b = {24'h0, d[7:0]};
    else if (a == `KE_OFS_STATUS) st = {24'h0, d[7:0]};
    chk_flag("enable", ctl[0], emulation_enable_bit);
    chk_flag("gate_a20", ctl[5], gate_a20_sequence_flag);
  endtask

  // One port cycle, then the input byte and status are read back directly.
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    logic       ack;
    logic [7:0] rd;
    logic       hit;
    logic       hold;
    hit  = ctl[0] && (a == `KE_PORT_DATA || a == `KE_PORT_CMD);
    hold = ctl[5] || (a == `KE_PORT_CMD && d == `KE_GA20_CMD);
    u_legacy_port_host.port(wr, a, d, ack, rd);
    chk_flag("io_ack", hit, ack);
    if (hit && !wr)
      chk_word("io_rdata", (a == `KE_PORT_DATA) ? out_b : st, {24'h0, rd});
    if (hit && !wr && a == `KE_PORT_DATA) st[0] = 1'b0;
    if (hit && wr) begin
      in_b  = {24'h0, d};
      st[3] = (a == `KE_PORT_CMD);
      if (!hold) st[1] = 1'b1;
      if (a == `KE_PORT_CMD) ctl[5] = (d == `KE_GA20_CMD);
    end
    mem(1'b0, `KE_OFS_INPUT, 32'h0);
    mem(1'b0, `KE_OFS_STATUS, 32'h0);
  endtask

  // Main sequence; random bytes never hit the gate A20 command.
  initial begin
    logic [7:0] r;
    err_count = 0;
    n_tests   = 0;
    {in_b, out_b, st, ctl} = '0;
    {mem_sel, mem_wr, mem_addr, mem_wdata} = '0;
    rst_b = 1'b0;
    void'($urandom(34557));
    repeat (2) @(posedge mclk);
    @(negedge mclk) rst_b = 1'b1;
    for (int i = 0; i < 5; i++) mem(1'b0, 12'h100 + 12'(4 * i), 32'h0);
    r = 8'($urandom);
    mem(1'b1, `KE_OFS_INPUT, {24'h0, r});
    mem(1'b0, `KE_OFS_STATUS, 32'h0);
    io(1'b1, `KE_PORT_DATA, 8'h5A);
    io(1'b0, `KE_PORT_CMD, 8'h00);
    mem(1'b1, `KE_OFS_CONTROL, 32'h1);
    io(1'b1, `KE_PORT_DATA, ~r);
    io(1'b1, `KE_PORT_CMD, 8'h20);
    io(1'b1, 16'h0061, r);
    mem(1'b1, `KE_OFS_OUTPUT, {24'h0, r});
    mem(1'b1, `KE_OFS_STATUS, 32'h1);
    mem(1'b0, `KE_OFS_OUTPUT, 32'h0);
    io(1'b0, `KE_PORT_CMD, 8'h00);
    io(1'b0, `KE_PORT_DATA, 8'h00);
    mem(1'b1, `KE_OFS_STATUS, 32'h0);
    io(1'b1, `KE_PORT_CMD, `KE_GA20_CMD);
    io(1'b1, `KE_PORT_DATA, r);
    mem(1'b1, `KE_OFS_CONTROL, 32'h1);
    for (int i = 0; i < 40; i++) begin
      r = 8'($urandom);
      if (r == `KE_GA20_CMD) r = 8'h00;
      if (i % 8 == 0) mem(1'b1, `KE_OFS_OUTPUT, {24'h0, ~r});
      io(1'($urandom), ($urandom % 2) ? `KE_PORT_CMD : `KE_PORT_DATA, r);
    end
    give_verdict();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("Error watchdog expired");
    give_verdict();
  end
endmodule // tb

`default_nettype wire
